// ===== src/cop_clr_sync.sv
// Register clear generator: asynchronous assertion, synchronised release
`timescale 1ns/10ps
module cop_clr_sync (
    input  wire logic core_clk,
    input  wire logic clr_async_n,
    output logic      clr_sync_n
);
    typedef struct packed {
        logic s1;
        logic s2;
    } cop_clr_t;

    cop_clr_t q;
    cop_clr_t next_q;

    always_comb begin
        next_q.s1 = 1'b1;
        next_q.s2 = q.s1;
    end

    always_ff @(posedge core_clk or negedge clr_async_n) begin
        if (!clr_async_n) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign clr_sync_n = q.s2;
endmodule : cop_clr_sync

// ===== src/cop_ctrl.sv
`timescale 1ns/10ps
module cop_ctrl
    import cop_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        srst,
    input  wire logic        config_request_n,
    input  wire logic        user_startup_clock,
    input  wire logic        termination_cal_done,
    input  wire logic        global_output_enable,
    input  wire logic        global_clear_n,
    input  wire logic        frame_opt_valid,
    input  wire logic        frame_init_opt,
    output logic             init_done_out,
    output logic             init_done_oe_n,
    output logic             io_tristate,
    output logic             reg_clear_n,
    output logic             config_serial_clock,
    output logic             user_mode,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    import cop_pkg::*;

    typedef struct packed {
        logic              cfg_s1;
        logic              cfg_s2;
        logic              uclk_s1;
        logic              uclk_s2;
        logic              uclk_s3;
        logic              cal_s1;
        logic              cal_s2;
        logic              oe_s1;
        logic              oe_s2;
        logic              clr_s1;
        logic              clr_s2;
        cop_state_t        state;
        logic [LEN_W-1:0]  cnt;
        logic              init_opt;
        logic              user_mode;
        logic [CTRL_W-1:0] ctrl;
        logic [LEN_W-1:0]  init_len;
        logic              pin_out;
        logic              pin_oe_n;
        logic              io_tristate;
        logic              serclk;
        logic              awready;
        logic              wready;
        logic              aw_have;
        logic [31:0]       aw_addr;
        logic              w_have;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              arready;
        logic              rvalid;
        logic [1:0]        rresp;
        logic [31:0]       rdata;
    } cop_state_reg_t;

    cop_state_reg_t q;
    cop_state_reg_t next_q;
    logic           clr_async_n;
    logic           uedge;
    logic           tick;

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic cop_sel_t reg_sel(input logic [31:0] a);
        if (a == OFS_CTRL)          reg_sel = SEL_CTRL;
        else if (a == OFS_INIT_LEN) reg_sel = SEL_LEN;
        else if (a == OFS_STATUS)   reg_sel = SEL_STAT;
        else                        reg_sel = SEL_NONE;
    endfunction : reg_sel

    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  strb);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) r[i*8 +: 8] = new_v[i*8 +: 8];
        end
        merge = r;
    endfunction : merge

    // Clear is applied asynchronously, released on the core clock
    assign clr_async_n = ~(q.ctrl[CB_CLR_EN] & ~global_clear_n);

    cop_clr_sync u_clr (
        .core_clk    (core_clk),
        .clr_async_n (clr_async_n),
        .clr_sync_n  (reg_clear_n)
    );

    assign uedge = q.uclk_s2 & ~q.uclk_s3;
    assign tick  = q.ctrl[CB_USR_CLK] ? uedge : 1'b1;

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        logic [31:0] wv;
        logic [31:0] st;
        wv = '0;
        st = '0;
        next_q = q;
        next_q.cfg_s1  = config_request_n;
        next_q.cfg_s2  = q.cfg_s1;
        next_q.uclk_s1 = user_startup_clock;
        next_q.uclk_s2 = q.uclk_s1;
        next_q.uclk_s3 = q.uclk_s2;
        next_q.cal_s1  = termination_cal_done;
        next_q.cal_s2  = q.cal_s1;
        next_q.oe_s1   = global_output_enable;
        next_q.oe_s2   = q.oe_s1;
        next_q.clr_s1  = global_clear_n;
        next_q.clr_s2  = q.clr_s1;

        // Initialization sequence
        case (q.state)
            ST_HOLD: begin
                next_q.init_opt = 1'b0;
                next_q.cnt = '0;
                if (q.cfg_s2) next_q.state = ST_LOAD;
            end
            ST_LOAD: begin
                if (frame_opt_valid) begin
                    next_q.init_opt = frame_init_opt;
                    next_q.state = ST_INIT;
                end
            end
            ST_INIT: begin
                if (tick) begin
                    next_q.cnt = q.cnt + 16'h0001;
                    if (q.cnt + 16'h0001 >= q.init_len) next_q.state = ST_CAL;
                end
            end
            ST_CAL: begin
                if (!q.ctrl[CB_CAL_GATE] || q.cal_s2) begin
                    next_q.state = ST_USER;
                end
            end
            ST_USER: begin
                next_q.state = ST_USER;
            end
            default: begin
                next_q.state = ST_HOLD;
            end
        endcase
        if (!q.cfg_s2) next_q.state = ST_HOLD;
        next_q.user_mode = (next_q.state == ST_USER);

        // Init-complete pin, open drain when init_opt is set, otherwise driven from CB_GP_OUT only in user mode with CB_GP_DRIVE set
        if (next_q.state == ST_HOLD) begin
            next_q.pin_out  = 1'b0;
            next_q.pin_oe_n = 1'b1;
        end else if (next_q.init_opt) begin
            next_q.pin_out  = 1'b0;
            next_q.pin_oe_n = next_q.user_mode;
        end else begin
            next_q.pin_out  = q.ctrl[CB_GP_OUT];
            next_q.pin_oe_n = ~(next_q.user_mode & q.ctrl[CB_GP_DRIVE]);
        end

        next_q.io_tristate = q.ctrl[CB_OE_EN] & ~q.oe_s2;

        // Serial configuration clock from the chosen source
        if (q.state == ST_LOAD || q.state == ST_INIT) begin
            if (q.ctrl[CB_SER_USR] ? uedge : 1'b1) begin
                next_q.serclk = ~q.serclk;
            end
        end else begin
            next_q.serclk = 1'b0;
        end

        // AXI4-Lite write
        if (s_axi_awvalid && q.awready) begin
            next_q.aw_have = 1'b1;
            next_q.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && q.wready) begin
            next_q.w_have = 1'b1;
            next_q.wdata  = s_axi_wdata;
            next_q.wstrb  = s_axi_wstrb;
        end
        if (q.bvalid && s_axi_bready) next_q.bvalid = 1'b0;
        if (q.aw_have && q.w_have && !q.bvalid) begin
            next_q.aw_have = 1'b0;
            next_q.w_have  = 1'b0;
            next_q.bvalid  = 1'b1;
            next_q.bresp   = RESP_OKAY;
            case (reg_sel(q.aw_addr))
                SEL_CTRL: begin
                    wv = merge({24'h00_0000, q.ctrl}, q.wdata, q.wstrb);
                    next_q.ctrl = wv[CTRL_W-1:0];
                end
                SEL_LEN: begin
                    wv = merge({16'h0000, q.init_len}, q.wdata, q.wstrb);
                    next_q.init_len = wv[LEN_W-1:0];
                end
                SEL_STAT: begin
                    next_q.bresp = RESP_OKAY;
                end
                default: begin
                    next_q.bresp = RESP_SLVERR;
                end
            endcase
        end
        next_q.awready = ~next_q.aw_have & ~next_q.bvalid;
        next_q.wready  = ~next_q.w_have & ~next_q.bvalid;

        // AXI4-Lite read
        st[SB_STATE +: 3]  = q.state;
        st[SB_USER]        = q.user_mode;
        st[SB_INIT_OPT]    = q.init_opt;
        st[SB_CAL]         = q.cal_s2;
        st[SB_OE_PIN]      = q.oe_s2;
        st[SB_CLR_PIN]     = q.clr_s2;
        st[SB_CFG_PIN]     = q.cfg_s2;
        st[SB_UCLK_PIN]    = q.uclk_s2;
        if (q.rvalid && s_axi_rready) next_q.rvalid = 1'b0;
        if (s_axi_arvalid && q.arready) begin
            next_q.rvalid = 1'b1;
            next_q.rresp  = RESP_OKAY;
            case (reg_sel(s_axi_araddr))
                SEL_CTRL: next_q.rdata = {24'h00_0000, q.ctrl};
                SEL_LEN:  next_q.rdata = {16'h0000, q.init_len};
                SEL_STAT: next_q.rdata = st;
                default: begin
                    next_q.rdata = '0;
                    next_q.rresp = RESP_SLVERR;
                end
            endcase
        end
        next_q.arready = ~next_q.rvalid;
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            q          <= '0;
            q.state    <= ST_HOLD;
            q.ctrl     <= CTRL_RST;
            q.init_len <= INIT_LEN_RST;
            q.pin_oe_n <= 1'b1;
        end else begin
            q <= next_q;
        end
    end

    assign init_done_out       = q.pin_out;
    assign init_done_oe_n      = q.pin_oe_n;
    assign io_tristate         = q.io_tristate;
    assign config_serial_clock = q.serclk;
    assign user_mode           = q.user_mode;
    assign s_axi_awready       = q.awready;
    assign s_axi_wready        = q.wready;
    assign s_axi_bvalid        = q.bvalid;
    assign s_axi_bresp         = q.bresp;
    assign s_axi_arready       = q.arready;
    assign s_axi_rvalid        = q.rvalid;
    assign s_axi_rresp         = q.rresp;
    assign s_axi_rdata         = q.rdata;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    chk_hold_released: assert property (
        !q.cfg_s2 |=> q.pin_oe_n)
        else $error("init pin driven while config request low");
    chk_init_pulls_low: assert property (
        (q.state == ST_INIT && q.init_opt) |-> (!q.pin_oe_n && !q.pin_out))
        else $error("init pin not low during initialization");
    chk_user_release: assert property (
        ($rose(q.user_mode) && q.init_opt) |-> q.pin_oe_n && $past(!q.pin_oe_n))
        else $error("init pin not released on entering user mode");
    chk_cal_gate_wait: assert property (
        (q.state == ST_CAL && q.ctrl[CB_CAL_GATE] && !q.cal_s2 && q.cfg_s2)
        |=> q.state == ST_CAL)
        else $error("left calibration wait before calibration done");
    chk_cal_no_wait: assert property (
        (q.state == ST_CAL && !q.ctrl[CB_CAL_GATE] && q.cfg_s2)
        |=> q.state == ST_USER)
        else $error("waited for calibration with gating off");
    chk_oe_tristate: assert property (
        (q.ctrl[CB_OE_EN] && !q.oe_s2) |=> q.io_tristate)
        else $error("output enable low did not tri-state");
    chk_oe_option_off: assert property (
        !q.ctrl[CB_OE_EN] |=> !q.io_tristate)
        else $error("tri-state with output enable option off");
    chk_usr_clk_pace: assert property (
        (q.state == ST_INIT && q.ctrl[CB_USR_CLK] && !uedge && q.cfg_s2)
        |=> $stable(q.cnt) && q.state == ST_INIT)
        else $error("init count moved without start-up clock edge");
    chk_serclk_source: assert property (
        (q.state == ST_INIT && q.ctrl[CB_SER_USR] && !uedge && q.cfg_s2)
        |=> $stable(q.serclk))
        else $error("serial clock toggled without start-up clock edge");
    chk_clear_applied: assert property (
        (q.ctrl[CB_CLR_EN] && !global_clear_n) |=> !reg_clear_n)
        else $error("register clear not applied");
endmodule : cop_ctrl

// ===== src/cop_pkg.sv
// Constants, register map and state codes for the option pin controller
package cop_pkg;
    localparam int unsigned        CLK_PERIOD_NS = 4;
    localparam logic [31:0]        OFS_CTRL      = 32'h0000_0000;
    localparam logic [31:0]        OFS_INIT_LEN  = 32'h0000_0004;
    localparam logic [31:0]        OFS_STATUS    = 32'h0000_0008;
    localparam int unsigned        CTRL_W        = 8;
    localparam int unsigned        LEN_W         = 16;
    localparam logic [CTRL_W-1:0]  CTRL_RST      = 8'h00;
    localparam logic [LEN_W-1:0]   INIT_LEN_RST  = 16'h0010;
    // Control bit positions
    localparam int unsigned        CB_USR_CLK    = 0;
    localparam int unsigned        CB_CAL_GATE   = 1;
    localparam int unsigned        CB_OE_EN      = 2;
    localparam int unsigned        CB_CLR_EN     = 3;
    localparam int unsigned        CB_SER_USR    = 4;
    localparam int unsigned        CB_GP_OUT     = 5;
    localparam int unsigned        CB_GP_DRIVE   = 6;
    // Status bit positions
    localparam int unsigned        SB_STATE      = 0;
    localparam int unsigned        SB_USER       = 3;
    localparam int unsigned        SB_INIT_OPT   = 4;
    localparam int unsigned        SB_CAL        = 5;
    localparam int unsigned        SB_OE_PIN     = 6;
    localparam int unsigned        SB_CLR_PIN    = 7;
    localparam int unsigned        SB_CFG_PIN    = 8;
    localparam int unsigned        SB_UCLK_PIN   = 9;
    localparam logic [1:0]         RESP_OKAY     = 2'h0;
    localparam logic [1:0]         RESP_SLVERR   = 2'h2;

    typedef enum logic [2:0] {
        ST_HOLD = 3'b000,
        ST_LOAD = 3'b001,
        ST_INIT = 3'b010,
        ST_CAL  = 3'b011,
        ST_USER = 3'b100
    } cop_state_t;

    typedef enum logic [1:0] {
        SEL_CTRL = 2'b00,
        SEL_LEN  = 2'b01,
        SEL_STAT = 2'b10,
        SEL_NONE = 2'b11
    } cop_sel_t;
endpackage : cop_pkg

// ===== test/cop_board.sv
// Board model: pin drivers, init pin pull-up, start-up clock, monitor
`timescale 1ns/10ps
module cop_board (
    input  wire logic core_clk,
    input  wire logic cfg_cmd,
    input  wire logic uclk_run,
    input  wire logic cal_cmd,
    input  wire logic oe_cmd,
    input  wire logic clr_cmd,
    input  wire logic init_done_out,
    input  wire logic init_done_oe_n,
    output logic      config_request_n,
    output logic      user_startup_clock,
    output logic      termination_cal_done,
    output logic      global_output_enable,
    output logic      global_clear_n,
    output logic      init_pin,
    output int        rise_cnt
);
    logic [2:0] div    = 3'h0;
    logic       pin_q  = 1'b1;
    logic       uclk_q = 1'b0;
    int         rise_q = 0;
    ////////////////////////////////////////////////////////////////////////
    // Pull-up holds the released open-drain pin high
    assign init_pin = init_done_oe_n ? 1'b1 : init_done_out;
    assign config_request_n = cfg_cmd;
    assign termination_cal_done = cal_cmd;
    assign global_output_enable = oe_cmd;
    assign global_clear_n = clr_cmd;
    assign user_startup_clock = uclk_q;
    assign rise_cnt = rise_q;
    ////////////////////////////////////////////////////////////////////////
    // Start-up clock runs only when asked, ten core cycles a period
    always @(posedge core_clk) begin
        if (uclk_run) begin
            div <= (div == 3'h4) ? 3'h0 : div + 3'h1;
            if (div == 3'h4)
                uclk_q <= ~uclk_q;
        end
    end
    // Monitor counts low-to-high moves of the init pin
    always @(posedge core_clk) begin
        pin_q <= init_pin;
        if (init_pin && !pin_q)
            rise_q <= rise_q + 1;
    end
endmodule : cop_board

// ===== test/test_cop_ctrl.sv
// Testbench for the option pin controller
`timescale 1ns/10ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin error_cnt++; \
    $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module test_cop_ctrl;
    import cop_pkg::*;
    logic core_clk, srst, cfg_cmd, uclk_run, cal_cmd, oe_cmd, clr_cmd;
    logic fv, fio, cfg_n, uclk, cal, oe, clr_n, init_pin, sc;
    logic init_done_out, init_done_oe_n, io_tristate, reg_clear_n;
    logic config_serial_clock, user_mode;
    logic [31:0] awaddr, wdata, araddr, rdata, d;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [1:0]  bresp, rresp, r;
    int          rise_cnt, rc, error_cnt, checked;

    cop_board board (.core_clk(core_clk), .cfg_cmd(cfg_cmd),
        .uclk_run(uclk_run), .cal_cmd(cal_cmd), .oe_cmd(oe_cmd),
        .clr_cmd(clr_cmd), .init_done_out(init_done_out),
        .init_done_oe_n(init_done_oe_n), .config_request_n(cfg_n),
        .user_startup_clock(uclk), .termination_cal_done(cal),
        .global_output_enable(oe), .global_clear_n(clr_n),
        .init_pin(init_pin), .rise_cnt(rise_cnt));
    cop_ctrl DUT (.core_clk(core_clk), .srst(srst),
        .config_request_n(cfg_n), .user_startup_clock(uclk),
        .termination_cal_done(cal), .global_output_enable(oe),
        .global_clear_n(clr_n), .frame_opt_valid(fv),
        .frame_init_opt(fio), .init_done_out(init_done_out),
        .init_done_oe_n(init_done_oe_n), .io_tristate(io_tristate),
        .reg_clear_n(reg_clear_n), .user_mode(user_mode),
        .config_serial_clock(config_serial_clock),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

    always #2 core_clk = ~core_clk;
    ////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [31:0] a, input logic [31:0] v);
        bit aw = 1'b0;
        bit w = 1'b0;
        @(posedge core_clk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw && w)) begin
            @(posedge core_clk);
            if (awvalid && awready) begin
                aw = 1'b1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                w = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge core_clk); while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [31:0] a);
        @(posedge core_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge core_clk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge core_clk); while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : rd
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        @(negedge core_clk);
    endtask : cyc
    task automatic wait_user(input int n);
        for (int i = 0; i < n && user_mode !== 1'b1; i++)
            @(negedge core_clk);
    endtask : wait_user
    task automatic start_init(input logic opt);
        @(posedge core_clk) cfg_cmd <= 1'b0;
        cyc(6);
        `CHK({init_done_oe_n, init_pin}, 2'b11)
        @(posedge core_clk) cfg_cmd <= 1'b1;
        cyc(6);
        rd(OFS_STATUS);
        `CHK(d[2:0], ST_LOAD)
        @(posedge core_clk) fv <= 1'b1;
        fio <= opt;
        @(posedge core_clk) fv <= 1'b0;
        @(negedge core_clk);
        `CHK(init_pin, ~opt)
    endtask : start_init
    task automatic test_done;
        $display("checked %0d error_cnt %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : test_done
    ////////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        rd(OFS_CTRL);
        `CHK({r, d}, {RESP_OKAY, 24'h0, CTRL_RST})
        rd(OFS_INIT_LEN);
        `CHK({r, d}, {RESP_OKAY, 16'h0, INIT_LEN_RST})
        rd(32'h0000_000C);
        `CHK({r, d}, {RESP_SLVERR, 32'h0})
        wr(32'h0000_0010, 32'hFF);
        `CHK(r, RESP_SLVERR)
        wr(OFS_STATUS, 32'hFFFF_FFFF);
        `CHK(r, RESP_OKAY)
        rd(OFS_STATUS);
        `CHK(d[2:0], ST_HOLD)
        wr(OFS_INIT_LEN, 32'h4);
        rd(OFS_INIT_LEN);
        `CHK({r, d}, {RESP_OKAY, 32'h4})
        $display("t_regs done");
    endtask : t_regs
    task automatic t_init;
        rc = rise_cnt;
        start_init(1'b1);
        wait_user(30);
        `CHK({user_mode, init_pin}, 2'b11)
        cyc(1);
        `CHK(rise_cnt - rc, 1)
        start_init(1'b0);
        wait_user(30);
        wr(OFS_CTRL, 32'h40);
        cyc(2);
        `CHK({init_done_oe_n, init_pin}, 2'b00)
        wr(OFS_CTRL, 32'h60);
        cyc(2);
        `CHK({init_done_oe_n, init_pin}, 2'b01)
        $display("t_init done");
    endtask : t_init
    task automatic t_gate;
        wr(OFS_CTRL, 32'h2);
        start_init(1'b1);
        cyc(40);
        `CHK({user_mode, init_pin}, 2'b00)
        @(posedge core_clk) cal_cmd <= 1'b1;
        wait_user(10);
        `CHK({user_mode, init_pin}, 2'b11)
        @(posedge core_clk) cal_cmd <= 1'b0;
        $display("t_gate done");
    endtask : t_gate
    task automatic t_uclk;
        wr(OFS_CTRL, 32'h11);
        start_init(1'b1);
        sc = config_serial_clock;
        cyc(40);
        `CHK({user_mode, config_serial_clock}, {1'b0, sc})
        @(posedge core_clk) uclk_run <= 1'b1;
        cyc(12);
        `CHK({user_mode, config_serial_clock}, {1'b0, ~sc})
        wait_user(300);
        `CHK(user_mode, 1'b1)
        @(posedge core_clk) uclk_run <= 1'b0;
        $display("t_uclk done");
    endtask : t_uclk
    task automatic t_oe;
        wr(OFS_CTRL, 32'h4);
        @(posedge core_clk) oe_cmd <= 1'b0;
        cyc(1);
        `CHK(io_tristate, 1'b0)
        cyc(4);
        `CHK(io_tristate, 1'b1)
        @(posedge core_clk) oe_cmd <= 1'b1;
        cyc(5);
        `CHK(io_tristate, 1'b0)
        wr(OFS_CTRL, 32'h0);
        @(posedge core_clk) oe_cmd <= 1'b0;
        cyc(5);
        `CHK(io_tristate, 1'b0)
        rd(OFS_STATUS);
        `CHK(d[SB_OE_PIN], 1'b0)
        @(posedge core_clk) oe_cmd <= 1'b1;
        $display("t_oe done");
    endtask : t_oe
    task automatic t_clr;
        @(posedge core_clk) clr_cmd <= 1'b0;
        cyc(3);
        `CHK(reg_clear_n, 1'b1)
        @(posedge core_clk) clr_cmd <= 1'b1;
        wr(OFS_CTRL, 32'h8);
        @(posedge core_clk) clr_cmd <= 1'b0;
        @(negedge core_clk);
        `CHK(reg_clear_n, 1'b0)
        @(posedge core_clk) clr_cmd <= 1'b1;
        cyc(3);
        `CHK(reg_clear_n, 1'b1)
        $display("t_clr done");
    endtask : t_clr
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {core_clk, cfg_cmd, uclk_run, cal_cmd, fv, fio} = 6'h00;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {awaddr, wdata, araddr} = 96'h0;
        {oe_cmd, clr_cmd, srst} = 3'h7;
        error_cnt = 0;
        checked = 0;
        repeat (3) @(posedge core_clk);
        srst <= 1'b0;
        t_regs();
        t_init();
        t_gate();
        t_uclk();
        t_oe();
        t_clr();
        test_done();
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        error_cnt++;
        test_done();
    end
endmodule : test_cop_ctrl
